// ==== logic/odc_pkg.sv ====
// Shared constants and carriers of the termination controller
package odc_pkg;
    // Register byte offsets
    localparam logic [3:0] ODC_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ODC_ADDR_TIMING = 4'h4;
    localparam logic [3:0] ODC_ADDR_STATUS = 4'h8;

    // Control, timing and status fields
    localparam int ODC_CTRL_NOM_LSB   = 0;
    localparam int ODC_CTRL_WR_LSB    = 3;
    localparam int ODC_CTRL_ASYNC_BIT = 5;
    localparam int ODC_CTRL_INIT_BIT  = 6;
    localparam int ODC_CTRL_SREF_BIT  = 7;
    localparam int ODC_CTRL_WLVL_BIT  = 8;
    localparam int ODC_TIM_CWL_LSB    = 0;
    localparam int ODC_TIM_AL_LSB     = 5;
    localparam int ODC_STAT_VIOL_BIT  = 3;

    // Reset values
    localparam logic [4:0] ODC_CWL_RST = 5'h05;
    localparam logic [4:0] ODC_AL_RST  = 5'h00;

    // Nominal and write strength codes
    localparam logic [2:0] ODC_NOM_OFF   = 3'h0;
    localparam logic [1:0] ODC_NOM_RSVD  = 2'h3;
    localparam logic [1:0] ODC_WR_OFF    = 2'h0;

    // Latency arithmetic, in clocks
    localparam logic [5:0] ODC_LAT_ADJ   = 6'h02;
    localparam logic [5:0] ODC_TAP_ADJ   = 6'h04;
    localparam int         ODC_DLY_DEPTH = 32;
    localparam logic [4:0] ODC_TAP_MAX   = 5'h1F;
    localparam logic [2:0] ODC_ODTH4     = 3'h4;
    localparam logic [2:0] ODC_ODTH8     = 3'h6;

    // Timing figures
    localparam int ODC_TCK_PS       = 10000;
    localparam int ODC_AONPD_MAX_PS = 8500;
    localparam int ODC_ASYNC_RAW    = ODC_AONPD_MAX_PS / ODC_TCK_PS;
    localparam int ODC_ASYNC_CYC    = (ODC_ASYNC_RAW < 1) ? 1 : ODC_ASYNC_RAW;
    localparam logic [7:0] ODC_MOD_CYC  = 8'h0C;
    localparam logic [7:0] ODC_SKEW_CYC = 8'h01;
    localparam logic [7:0] ODC_ONE_CK   = 8'h01;

    typedef struct packed {
        logic       wr_cmd;
        logic       wr_bc4;
        logic       rd_busy;
    } odc_cmd_s;

    typedef struct packed {
        logic       on;
        logic       is_wr;
        logic [2:0] code;
    } odc_rtt_s;

    typedef struct packed {
        logic [2:0] nom_code;
        logic [1:0] wr_code;
        logic       async_mode;
        logic       init_done;
        logic       self_ref;
        logic       wr_level;
        logic [4:0] cwl;
        logic [4:0] al;
    } odc_cfg_s;

    typedef struct packed {
        logic       settling;
        logic       pin_viol;
        logic       rsvd_code;
        logic       is_wr;
        logic       on;
    } odc_stat_s;
endpackage

// ==== logic/odc_dly.sv ====
// Tapped delay line with selectable tap
`timescale 1ns/100ps
module odc_dly import odc_pkg::*; #(
    parameter int W     = 1,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    // Data
    input  wire logic [W-1:0]             d,
    input  wire logic [$clog2(DEPTH)-1:0] sel,
    output      logic [W-1:0]             q
);
    logic [DEPTH-1:0][W-1:0] sh_reg;
    logic [DEPTH-1:0][W-1:0] sh_next;

    always_comb begin
        sh_next = {sh_reg[DEPTH-2:0], d};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    assign q = sh_reg[sel];
endmodule

// ==== logic/odc_regs.sv ====
// Avalon-MM register file of the termination controller
`timescale 1ns/100ps
module odc_regs import odc_pkg::*; (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output      logic [31:0] avs_readdata,
    output      logic        avs_waitrequest,
    // Block side
    input  wire odc_stat_s   stat,
    output      odc_cfg_s    cfg,
    output      logic        mr1_load,
    output      logic        viol_clr
);
    logic [31:0] ctrl_reg, ctrl_next, tim_reg, tim_next, rd_reg, rd_next;
    logic        ack_reg, ack_next, wr_go;
    logic [31:0] mask;

    always_comb begin
        mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        ack_next  = (avs_read | avs_write) & ~ack_reg;
        wr_go     = avs_write & ack_reg;
        ctrl_next = ctrl_reg;
        tim_next  = tim_reg;
        rd_next   = rd_reg;
        if (wr_go && avs_address == ODC_ADDR_CTRL) begin
            ctrl_next = (ctrl_reg & ~mask) | (avs_writedata & mask);
        end
        if (wr_go && avs_address == ODC_ADDR_TIMING) begin
            tim_next = (tim_reg & ~mask) | (avs_writedata & mask);
        end
        if (avs_read && !ack_reg) begin
            case (avs_address)
                ODC_ADDR_CTRL:   rd_next = ctrl_reg;
                ODC_ADDR_TIMING: rd_next = tim_reg;
                ODC_ADDR_STATUS: rd_next = {27'h0, stat};
                default:         rd_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_reg <= 32'h0;
            tim_reg  <= {22'h0, ODC_AL_RST, ODC_CWL_RST};
            rd_reg   <= 32'h0;
            ack_reg  <= 1'b0;
        end else begin
            ctrl_reg <= {23'h0, ctrl_next[8:0]};
            tim_reg  <= {22'h0, tim_next[9:0]};
            rd_reg   <= rd_next;
            ack_reg  <= ack_next;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata    = rd_reg;
    assign mr1_load = wr_go && avs_address == ODC_ADDR_CTRL && avs_byteenable[0];
    assign viol_clr = wr_go && avs_address == ODC_ADDR_STATUS && avs_byteenable[0]
                      && avs_writedata[ODC_STAT_VIOL_BIT];
    assign cfg.nom_code   = ctrl_reg[ODC_CTRL_NOM_LSB +: 3];
    assign cfg.wr_code    = ctrl_reg[ODC_CTRL_WR_LSB +: 2];
    assign cfg.async_mode = ctrl_reg[ODC_CTRL_ASYNC_BIT];
    assign cfg.init_done  = ctrl_reg[ODC_CTRL_INIT_BIT];
    assign cfg.self_ref   = ctrl_reg[ODC_CTRL_SREF_BIT];
    assign cfg.wr_level   = ctrl_reg[ODC_CTRL_WLVL_BIT];
    assign cfg.cwl        = tim_reg[ODC_TIM_CWL_LSB +: 5];
    assign cfg.al         = tim_reg[ODC_TIM_AL_LSB +: 5];
endmodule

// ==== logic/odc_term_ctrl.sv ====
// On-die termination control: nominal, dynamic and latency handling
// Operation
// - Nominal strength comes from the three-bit field, drives data, strobe, mask pads.
// - Field selects divisors 2, 4, 6, 8 or 12 of the reference resistance.
// - Nominal termination only after init and calibration, not reading or self refresh.
// - Sync turn-on follows registered pin high after write plus additive latency minus two.
// - Sync turn-off follows registered pin change after the same latency.
// - Async mode switches termination within 2 to 8.5 ns of the pin; the logic switches two clocks after the pin.
// - Turn-off completes half a clock after the sync latency.
// - Write termination replaces nominal during each burst, then nominal returns.
// - Pin tied high, nominal off, write termination on: terminate only in writes.
// - Tied-high case tolerates pin high where it should be low.
// - After a load, termination settles within latency, skew, update delay, one clock.
// - Dynamic termination enabled when either write-strength bit is set.
// - Write strength starts write latency minus two after a registered write.
`timescale 1ns/100ps
module odc_term_ctrl import odc_pkg::*; (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output      logic [31:0] avs_readdata,
    output      logic        avs_waitrequest,
    // Controller side
    input  wire logic        odt_pin,
    input  wire odc_cmd_s    cmd,
    // Termination to pads
    output      odc_rtt_s    rtt
);
    odc_cfg_s   cfg;
    odc_stat_s  stat;
    logic       mr1_load, viol_clr;
    logic       pin_reg, pin_next;
    logic [1:0] wcmd_reg, wcmd_next;
    logic       pin_dly;
    logic [1:0] wr_tap;
    logic [5:0] lat;
    logic [4:0] tap_sel;
    logic       nom_en, dyn_en, rsvd, tied, permit, pin_eff;
    logic [2:0] win_reg, win_next;
    logic       win_on;
    odc_rtt_s   rtt_reg, rtt_next;
    logic       viol_reg, viol_next;
    logic [7:0] set_reg, set_next;

    odc_regs u_regs (
        .sys_clk         (sys_clk),
        .sys_rst         (sys_rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_byteenable  (avs_byteenable),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .stat            (stat),
        .cfg             (cfg),
        .mr1_load        (mr1_load),
        .viol_clr        (viol_clr)
    );

    always_comb begin
        lat = {1'b0, cfg.cwl} + {1'b0, cfg.al} - ODC_LAT_ADJ;
        if ({1'b0, cfg.cwl} + {1'b0, cfg.al} < ODC_TAP_ADJ) begin
            tap_sel = 5'h0;
        end else if ({1'b0, cfg.cwl} + {1'b0, cfg.al} - ODC_TAP_ADJ > {1'b0, ODC_TAP_MAX}) begin
            tap_sel = ODC_TAP_MAX;
        end else begin
            tap_sel = 5'({1'b0, cfg.cwl} + {1'b0, cfg.al} - ODC_TAP_ADJ);
        end
    end

    always_comb begin
        pin_next  = odt_pin;
        wcmd_next = {cmd.wr_cmd, cmd.wr_bc4};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_reg  <= 1'b0;
            wcmd_reg <= 2'h0;
        end else begin
            pin_reg  <= pin_next;
            wcmd_reg <= wcmd_next;
        end
    end

    odc_dly #(.W(1), .DEPTH(ODC_DLY_DEPTH)) u_pin_dly (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       (pin_reg),
        .sel     (tap_sel),
        .q       (pin_dly)
    );

    odc_dly #(.W(2), .DEPTH(ODC_DLY_DEPTH)) u_wr_dly (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       (wcmd_reg),
        .sel     (tap_sel),
        .q       (wr_tap)
    );

    always_comb begin
        rsvd   = cfg.nom_code[2:1] == ODC_NOM_RSVD;
        nom_en = cfg.nom_code != ODC_NOM_OFF && !rsvd;
        dyn_en = cfg.wr_code != ODC_WR_OFF;
        tied   = cfg.nom_code == ODC_NOM_OFF && dyn_en;
        // gate on init, read, self refresh
        permit = cfg.init_done && !cfg.self_ref && !cmd.rd_busy;
        // async path skips the latency line
        pin_eff = cfg.async_mode ? pin_reg : pin_dly;
    end

    always_comb begin
        win_next = win_reg;
        if (wr_tap[1] && dyn_en) begin
            win_next = wr_tap[0] ? ODC_ODTH4 : ODC_ODTH8;
        end else if (win_reg != 3'h0) begin
            win_next = win_reg - 3'h1;
        end
        win_on = win_next != 3'h0;
    end

    always_comb begin
        rtt_next.on    = pin_eff && permit && (nom_en || (dyn_en && win_on));
        rtt_next.is_wr = rtt_next.on && dyn_en && win_on;
        rtt_next.code  = rtt_next.is_wr ? {1'b0, cfg.wr_code} : cfg.nom_code;
    end

    // pin high in a read is tolerated when tied
    always_comb begin
        viol_next = viol_reg;
        if (viol_clr) begin
            viol_next = 1'b0;
        end
        if (odt_pin && cmd.rd_busy && !tied) begin
            viol_next = 1'b1;
        end
    end

    always_comb begin
        set_next = set_reg;
        if (mr1_load) begin
            set_next = {2'b00, lat} + ODC_SKEW_CYC + ODC_MOD_CYC + ODC_ONE_CK;
        end else if (set_reg != 8'h0) begin
            set_next = set_reg - 8'h1;
        end
    end

    // turn-off lands on the latency edge; pad adds the half clock
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            win_reg  <= 3'h0;
            rtt_reg  <= '0;
            viol_reg <= 1'b0;
            set_reg  <= 8'h0;
        end else begin
            win_reg  <= win_next;
            rtt_reg  <= rtt_next;
            viol_reg <= viol_next;
            set_reg  <= set_next;
        end
    end

    assign rtt            = rtt_reg;
    assign stat.on        = rtt_reg.on;
    assign stat.is_wr     = rtt_reg.is_wr;
    assign stat.rsvd_code = rsvd;
    assign stat.pin_viol  = viol_reg;
    assign stat.settling  = set_reg != 8'h0;

    // Checks
    sequence s_pin_rise3;
        $rose(pin_reg) && !cfg.async_mode && lat == 6'h03 && nom_en && permit;
    endsequence
    sequence s_wr_tap;
        wr_tap[1] && dyn_en;
    endsequence

    property p_sync_on;
        @(posedge sys_clk) disable iff (sys_rst)
        s_pin_rise3 ##1 (permit && !cfg.async_mode && nom_en) [*3] |-> rtt.on;
    endproperty
    a_sync_on: assert property (p_sync_on) else $error("sync turn-on late");

    property p_sync_off;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(pin_reg) && !cfg.async_mode && lat == 6'h03 ##1 !cfg.async_mode [*2]
        |=> !rtt.on;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync turn-off late");

    property p_async;
        @(posedge sys_clk) disable iff (sys_rst)
        cfg.async_mode && pin_reg && permit && nom_en |=> rtt.on;
    endproperty
    a_async: assert property (p_async) else $error("async turn-on missed");

    property p_no_read;
        @(posedge sys_clk) disable iff (sys_rst)
        cmd.rd_busy || cfg.self_ref || !cfg.init_done |=> !rtt.on;
    endproperty
    a_no_read: assert property (p_no_read) else $error("termination while barred");

    property p_win4;
        @(posedge sys_clk) disable iff (sys_rst)
        // A later write may restart the window
        s_wr_tap and wr_tap[0] |=> (win_reg != 3'h0) [*4] ##1 (win_reg == 3'h0 || wr_tap[1]
            || $past(wr_tap[1]) || $past(wr_tap[1], 2) || $past(wr_tap[1], 3)
            || $past(wr_tap[1], 4));
    endproperty
    a_win4: assert property (p_win4) else $error("chopped window length");

    property p_win8;
        @(posedge sys_clk) disable iff (sys_rst)
        s_wr_tap and !wr_tap[0] |=> (win_reg != 3'h0) [*6];
    endproperty
    a_win8: assert property (p_win8) else $error("burst window short");

    property p_nodyn;
        @(posedge sys_clk) disable iff (sys_rst)
        !dyn_en |=> !rtt.is_wr || $past(dyn_en);
    endproperty
    a_nodyn: assert property (p_nodyn) else $error("write strength with dynamic off");

    property p_tied;
        @(posedge sys_clk) disable iff (sys_rst)
        tied && !viol_reg |=> !viol_reg;
    endproperty
    a_tied: assert property (p_tied) else $error("tied pin flagged");

    property p_nom_code;
        @(posedge sys_clk) disable iff (sys_rst)
        rtt.on && !rtt.is_wr |-> rtt.code == $past(cfg.nom_code) && !$past(rsvd);
    endproperty
    a_nom_code: assert property (p_nom_code) else $error("nominal code wrong");

    property p_settle;
        @(posedge sys_clk) disable iff (sys_rst)
        mr1_load |=> stat.settling [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("settle window short");

    property p_viol_set;
        @(posedge sys_clk) disable iff (sys_rst)
        odt_pin && cmd.rd_busy && !tied |=> stat.pin_viol;
    endproperty
    a_viol_set: assert property (p_viol_set) else $error("read violation missed");

    property p_viol_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        stat.pin_viol && !viol_clr |=> stat.pin_viol;
    endproperty
    a_viol_hold: assert property (p_viol_hold) else $error("violation lost");

    property p_rsvd_off;
        @(posedge sys_clk) disable iff (sys_rst)
        rsvd && !dyn_en |=> !rtt.on;
    endproperty
    a_rsvd_off: assert property (p_rsvd_off) else $error("reserved code terminates");

    property p_wr_code;
        @(posedge sys_clk) disable iff (sys_rst)
        rtt.is_wr |-> rtt.code == {1'b0, $past(cfg.wr_code)};
    endproperty
    a_wr_code: assert property (p_wr_code) else $error("write code wrong");

    property p_async_off;
        @(posedge sys_clk) disable iff (sys_rst)
        cfg.async_mode && !pin_reg |=> !rtt.on;
    endproperty
    a_async_off: assert property (p_async_off) else $error("async turn-off missed");

    property p_tied_only;
        @(posedge sys_clk) disable iff (sys_rst)
        tied |=> !rtt.on || rtt.is_wr;
    endproperty
    a_tied_only: assert property (p_tied_only) else $error("tied case off-write on");
endmodule

// ==== verification/odc_ctrl_model.sv ====
// Controller-side model driving the termination pin and commands
`timescale 1ns/100ps
module odc_ctrl_model import odc_pkg::*; (
    // Clock and reset
    input  wire logic     sys_clk,
    input  wire logic     sys_rst,
    // Requests from the test sequence
    input  wire logic     want_odt,
    input  wire logic     req_wr,
    input  wire logic     req_bc4,
    input  wire logic     req_rd,
    input  wire logic     tied_high,
    input  wire logic     break_rd,
    // Device side
    output      logic     odt_pin,
    output      odc_cmd_s cmd
);
    logic [2:0] hold_reg;
    logic [2:0] hold_next;
    logic       prev_reg;

    always_comb begin
        hold_next = (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;
        if (odt_pin && req_wr) begin
            hold_next = (req_bc4 ? ODC_ODTH4 : ODC_ODTH8) - 3'h1;
        end else if (odt_pin && !prev_reg) begin
            hold_next = ODC_ODTH4 - 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hold_reg <= 3'h0;
            prev_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            prev_reg <= odt_pin;
        end
    end

    // pin low in reads unless tied or break_rd is set
    assign odt_pin = tied_high | ((want_odt | (hold_reg != 3'h0)) & !(req_rd & !break_rd));
    // writes may go with pin low
    assign cmd = '{wr_cmd: req_wr, wr_bc4: req_bc4, rd_busy: req_rd};
endmodule

// ==== verification/tb_top.sv ====
// Self-checking testbench of the termination controller
`timescale 1ns/100ps
module tb_top import odc_pkg::*;;
    logic        sys_clk;
    logic        sys_rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        odt_pin;
    odc_cmd_s    cmd;
    odc_rtt_s    rtt;
    logic        want_odt;
    logic        req_wr;
    logic        req_bc4;
    logic        req_rd;
    logic        tied_high;
    logic        break_rd;
    int          fail_count;
    int          samples_checked;
    int          lat;
    int          nb;
    logic [2:0]  c;
    logic [1:0]  wc;
    logic        on_e;
    logic [4:0]  cwl_t [4] = '{5'h05, 5'h06, 5'h04, 5'h03};
    logic [4:0]  al_t [4]  = '{5'h00, 5'h01, 5'h00, 5'h00};
    logic [1:0]  wc_t [5]  = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
    logic        bc_t [5]  = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    odc_term_ctrl u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .odt_pin(odt_pin), .cmd(cmd), .rtt(rtt));
    odc_ctrl_model u_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .want_odt(want_odt),
        .req_wr(req_wr), .req_bc4(req_bc4), .req_rd(req_rd), .tied_high(tied_high),
        .break_rd(break_rd), .odt_pin(odt_pin), .cmd(cmd));

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_pad(input string name, input logic on, input logic wr, input logic [2:0] cd);
        samples_checked++;
        if (rtt.on !== on || rtt.is_wr !== wr || (on && rtt.code !== cd)) begin
            fail_count++;
            $display("mismatch %s expected %b%b%b seen %b", name, on, wr, cd, rtt);
        end
    endtask

    // Holds the request until waitrequest is seen low at an edge
    task automatic bus_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] data,
                            input logic [3:0] be, output logic [31:0] rdata);
        int   n;
        logic w;
        n = 0;
        @(posedge sys_clk);
        avs_address    <= addr;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_byteenable <= be;
        avs_writedata  <= data;
        do begin
            #1;
            w = avs_waitrequest;
            rdata = avs_readdata;
            @(posedge sys_clk);
            n++;
        end while (w !== 1'b0 && n < 50);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        cmp_word("bus_answer", 32'h0, {31'h0, w});
    endtask

    task automatic bus_wr(input logic [3:0] addr, input logic [31:0] data, input logic [3:0] be);
        logic [31:0] d;
        bus_xfer(1'b1, addr, data, be, d);
    endtask

    task automatic bus_rd(input string name, input logic [3:0] addr, input logic [31:0] exp,
                          input logic [31:0] mask);
        logic [31:0] d;
        bus_xfer(1'b0, addr, 32'h0, 4'hF, d);
        cmp_word(name, exp & mask, d & mask);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic drive_pin(input logic v);
        @(posedge sys_clk);
        want_odt <= v;
    endtask

    task automatic do_write(input logic bc4);
        @(posedge sys_clk);
        req_wr  <= 1'b1;
        req_bc4 <= bc4;
        @(posedge sys_clk);
        req_wr  <= 1'b0;
    endtask

    function automatic logic [31:0] ctrl_w(input logic [2:0] nom, input logic [1:0] wr,
                                           input logic as, input logic init, input logic wl);
        return {23'h0, wl, 1'b0, init, as, wr, nom};
    endfunction

    // Writes control, then waits for the settling flag to clear
    task automatic set_cfg(input logic [31:0] w);
        logic [31:0] d;
        int          n;
        bus_wr(ODC_ADDR_CTRL, w, 4'hF);
        bus_rd("settle_set", ODC_ADDR_STATUS, 32'h10, 32'h10);
        n = 0;
        do begin
            bus_xfer(1'b0, ODC_ADDR_STATUS, 32'h0, 4'hF, d);
            n++;
        end while (d[4] !== 1'b0 && n < 40);
        cmp_word("settle_end", 32'h0, {31'h0, d[4]});
    endtask

    initial begin
        #400000;
        fail_count++;
        $display("mismatch watchdog expected done seen hang");
        report_and_stop();
    end

    initial begin
        fail_count = 0;
        samples_checked = 0;
        {avs_address, avs_read, avs_write, avs_byteenable, avs_writedata} = '0;
        {want_odt, req_wr, req_bc4, req_rd, tied_high, break_rd} = '0;
        sys_rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        bus_rd("ctrl_rst", ODC_ADDR_CTRL, 32'h0, '1);
        bus_rd("timing_rst", ODC_ADDR_TIMING, {22'h0, ODC_AL_RST, ODC_CWL_RST}, '1);
        bus_wr(4'hC, 32'hFFFF_FFFF, 4'hF);
        bus_rd("unmapped", 4'hC, 32'h0, '1);
        bus_wr(ODC_ADDR_CTRL, 32'h0000_01FF, 4'h2);
        bus_rd("ctrl_lane", ODC_ADDR_CTRL, 32'h0000_0100, '1);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            bus_wr(ODC_ADDR_TIMING, {22'h0, al_t[i], cwl_t[i]}, 4'hF);
            set_cfg(ctrl_w(3'h1, 2'h0, 1'b0, 1'b1, 1'b0));
            lat = int'(cwl_t[i]) + int'(al_t[i]) - 2;
            lat = (lat < 2) ? 2 : lat;
            drive_pin(1'b1);
            step(lat);
            cmp_pad("on_early", 1'b0, 1'b0, 3'h1);
            step(1);
            cmp_pad("on_edge", 1'b1, 1'b0, 3'h1);
            step(8);
            drive_pin(1'b0);
            step(lat);
            cmp_pad("off_early", 1'b1, 1'b0, 3'h1);
            step(1);
            cmp_pad("off_edge", 1'b0, 1'b0, 3'h1);
        end
        $display("test latency done");
        bus_wr(ODC_ADDR_TIMING, 32'h0000_0005, 4'hF);
        lat = 3;
        drive_pin(1'b1);
        for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            on_e = (c != ODC_NOM_OFF) && (c[2:1] != ODC_NOM_RSVD);
            set_cfg(ctrl_w(c, 2'h0, 1'b0, 1'b1, 1'b0));
            cmp_pad("nom_code", on_e, 1'b0, c);
            bus_rd("nom_stat", ODC_ADDR_STATUS, {29'h0, !on_e && c != 3'h0, 1'b0, on_e}, '1);
        end
        set_cfg(ctrl_w(3'h1, 2'h0, 1'b0, 1'b0, 1'b0));
        cmp_pad("no_init", 1'b0, 1'b0, 3'h1);
        set_cfg(ctrl_w(3'h1, 2'h0, 1'b0, 1'b1, 1'b0) | 32'h80);
        cmp_pad("self_ref", 1'b0, 1'b0, 3'h1);
        drive_pin(1'b0);
        set_cfg(ctrl_w(3'h1, 2'h0, 1'b1, 1'b1, 1'b0));
        drive_pin(1'b1);
        step(1);
        cmp_pad("async_on_early", 1'b0, 1'b0, 3'h1);
        step(1);
        cmp_pad("async_on", 1'b1, 1'b0, 3'h1);
        step(4);
        drive_pin(1'b0);
        step(2);
        cmp_pad("async_off", 1'b0, 1'b0, 3'h1);
        $display("test nominal done");
        drive_pin(1'b1);
        for (int k = 0; k < 5; k++) begin
            wc = wc_t[k];
            nb = bc_t[k] ? 4 : 6;
            set_cfg(ctrl_w(3'h3, wc, 1'b0, 1'b1, 1'b0));
            do_write(bc_t[k]);
            step(lat - 1);
            cmp_pad("wr_before", 1'b1, 1'b0, 3'h3);
            step(1);
            cmp_pad("wr_start", 1'b1, wc != 2'h0, (wc != 2'h0) ? {1'b0, wc} : 3'h3);
            step(nb - 1);
            cmp_pad("wr_last", 1'b1, wc != 2'h0, (wc != 2'h0) ? {1'b0, wc} : 3'h3);
            step(1);
            cmp_pad("wr_after", 1'b1, 1'b0, 3'h3);
        end
        drive_pin(1'b0);
        step(6);
        do_write(1'b1);
        step(lat + 1);
        bus_rd("wr_pin_low", ODC_ADDR_STATUS, 32'h0, 32'h9);
        $display("test dynamic done");
        set_cfg(ctrl_w(3'h1, 2'h0, 1'b0, 1'b1, 1'b0));
        drive_pin(1'b1);
        step(6);
        @(posedge sys_clk);
        break_rd <= 1'b1;
        req_rd   <= 1'b1;
        step(2);
        cmp_pad("read_forces_off", 1'b0, 1'b0, 3'h1);
        bus_rd("viol_set", ODC_ADDR_STATUS, 32'h8, 32'h8);
        @(posedge sys_clk);
        break_rd <= 1'b0;
        req_rd   <= 1'b0;
        bus_wr(ODC_ADDR_STATUS, 32'h8, 4'hF);
        bus_rd("viol_clear", ODC_ADDR_STATUS, 32'h0, 32'h8);
        @(posedge sys_clk);
        req_rd <= 1'b1;
        step(6);
        bus_rd("read_legal", ODC_ADDR_STATUS, 32'h0, 32'h8);
        @(posedge sys_clk);
        req_rd <= 1'b0;
        drive_pin(1'b0);
        $display("test read done");
        tied_high <= 1'b1;
        set_cfg(ctrl_w(3'h1, 2'h0, 1'b0, 1'b1, 1'b1));
        set_cfg(ctrl_w(3'h0, 2'h1, 1'b0, 1'b1, 1'b0));
        step(4);
        cmp_pad("tied_idle", 1'b0, 1'b0, 3'h0);
        do_write(1'b0);
        step(lat);
        cmp_pad("tied_wr", 1'b1, 1'b1, 3'h1);
        step(6);
        cmp_pad("tied_after", 1'b0, 1'b0, 3'h0);
        @(posedge sys_clk);
        req_rd <= 1'b1;
        step(3);
        bus_rd("tied_read", ODC_ADDR_STATUS, 32'h0, 32'h8);
        @(posedge sys_clk);
        req_rd    <= 1'b0;
        tied_high <= 1'b0;
        $display("test tied done");
        report_and_stop();
    end
endmodule
